//--- include/kasd_dec_if.sv
// Carrier between the register side and the segment decoder
`timescale 1ns/1ns
interface kasd_dec_if;
    import kasd_pkg::*;
    logic                kernel;
    logic                ext64;
    logic                error_level_bit;
    logic [2:0]          direct_window_cache_field;
    logic [VA_W-1:0]     va;
    kasd_seg_type        seg;
    logic                mapped;
    logic                cacheable;
    logic [PA_W-1:0]     paddr;
    logic                addr_err;
    modport dec (
        input  kernel, ext64, error_level_bit, direct_window_cache_field, va,
        output seg, mapped, cacheable, paddr, addr_err
    );
    modport core (
        output kernel, ext64, error_level_bit, direct_window_cache_field, va,
        input  seg, mapped, cacheable, paddr, addr_err
    );
endinterface

//--- include/kasd_pkg.sv
// Constants and types for the kernel address segment decoder
// Behaviour
// - Kernel when privilege 00, exception or error set
// - Extended addressing bit picks 32 or 64-bit map
// - Exception enters kernel; return restores prior mode
// - 32-bit addresses sign-extend bit 31 upward
// - Base plus offset overflow gives undefined result
// - Low 2G in 32-bit kernel is mapped user
// - Error level makes low 2G unmapped, uncached
// - Top bits 100 direct cached, cache field decides
// - Top bits 101 direct uncached, minus A000 0000
// - Top bits 110 mapped supervisor segment
// - Top bits 111 mapped kernel segment
// - 64-bit high bits 00 mapped user segment
// - 64-bit high bits 01 mapped supervisor segment
// - 64-bit high bits 10 physical; bits 58:32 error
// - Physical window yields 4-Gbyte physical address
// - 64-bit high bits 11 mapped kernel segment
// - Compat cached window maps to low 512M
// - Compat uncached window maps to low 512M
// - Compat supervisor window is TLB-mapped
// - Compat kernel window is TLB-mapped
// - Unused 64-bit holes raise address error
// - Bits 30:29 pick the compat window
package kasd_pkg;
    localparam int unsigned VA_W      = 64;
    localparam int unsigned PA_W      = 32;
    localparam int unsigned ID_W      = 8;
    localparam int unsigned CNT_W     = 16;
    // Register byte offsets
    localparam logic [11:0] OFS_STATUS = 12'h000;
    localparam logic [11:0] OFS_CONFIG = 12'h004;
    localparam logic [11:0] OFS_SPACE  = 12'h008;
    localparam logic [11:0] OFS_STATE  = 12'h00C;
    localparam logic [11:0] OFS_ERR_LO = 12'h010;
    localparam logic [11:0] OFS_ERR_HI = 12'h014;
    localparam logic [11:0] OFS_ERR_CT = 12'h018;
    // Field positions
    localparam int unsigned ST_XADDR   = 0;
    localparam int unsigned ST_EXC     = 1;
    localparam int unsigned ST_ERRLVL  = 2;
    localparam int unsigned ST_PRIV    = 3;
    localparam int unsigned STA_KERNEL = 0;
    localparam int unsigned STA_EXT    = 1;
    localparam int unsigned STA_ERR    = 8;
    // Reset values
    localparam logic [1:0]  PRIV_RST   = 2'h0;
    localparam logic        ERL_RST    = 1'b1;
    localparam logic [2:0]  CFIELD_RST = 3'h2;
    localparam logic [7:0]  SPACE_RST  = 8'h00;
    // Decode constants
    localparam logic [1:0]  PRIV_KERNEL   = 2'h0;
    localparam logic [2:0]  TOP_CACHED    = 3'h4;
    localparam logic [2:0]  TOP_UNCACHED  = 3'h5;
    localparam logic [2:0]  TOP_SUPER     = 3'h6;
    localparam logic [2:0]  TOP_KERNEL    = 3'h7;
    localparam logic [1:0]  HI_USER       = 2'h0;
    localparam logic [1:0]  HI_SUPER      = 2'h1;
    localparam logic [1:0]  HI_PHYS       = 2'h2;
    localparam logic [1:0]  HI_KERNEL     = 2'h3;
    localparam logic [2:0]  ATTR_UNCACHED = 3'h2;
    localparam logic [31:0] CACHED_BASE   = 32'h8000_0000;
    localparam logic [31:0] UNCACHED_BASE = 32'hA000_0000;
    localparam logic [63:0] USER_TOP      = 64'h0000_00FF_FFFF_FFFF;
    localparam logic [63:0] SUPER_TOP     = 64'h4000_00FF_FFFF_FFFF;
    localparam logic [63:0] XKSEG_TOP     = 64'hC000_00FF_7FFF_FFFF;

    typedef enum logic [3:0] {
        SEG_NONE, SEG_USER, SEG_DCACHED, SEG_DUNCACHED, SEG_SUPER,
        SEG_KTOP, SEG_XUSER, SEG_XSUPER, SEG_XPHYS, SEG_XKERNEL,
        SEG_CCACHED, SEG_CUNCACHED, SEG_CSUPER, SEG_CKERNEL, SEG_HOLE
    } kasd_seg_type;

    function automatic logic kasd_cache_ok(input logic [2:0] attr);
        return attr != ATTR_UNCACHED;
    endfunction
endpackage

//--- rtl/kasd_seg_decode.sv
// Combinational kernel segment decode of one 64-bit address
`timescale 1ns/1ns
module kasd_seg_decode (
    kasd_dec_if.dec d
);
    import kasd_pkg::*;

    always_comb begin
        d.seg       = SEG_NONE;
        d.mapped    = 1'b0;
        d.cacheable = 1'b0;
        d.paddr     = '0;
        d.addr_err  = 1'b0;
        if (!d.kernel) begin
            d.seg = SEG_NONE;
        end else if (!d.ext64) begin
            case (d.va[31:29])
                TOP_CACHED: begin
                    d.seg       = SEG_DCACHED;
                    d.paddr     = d.va[31:0] - CACHED_BASE;
                    d.cacheable = kasd_cache_ok(d.direct_window_cache_field);
                end
                TOP_UNCACHED: begin
                    d.seg   = SEG_DUNCACHED;
                    d.paddr = d.va[31:0] - UNCACHED_BASE;
                end
                TOP_SUPER: begin
                    d.seg    = SEG_SUPER;
                    d.mapped = 1'b1;
                end
                TOP_KERNEL: begin
                    d.seg    = SEG_KTOP;
                    d.mapped = 1'b1;
                end
                default: begin
                    d.seg    = SEG_USER;
                    d.mapped = !d.error_level_bit;
                    d.paddr  = d.error_level_bit ? d.va[31:0] : '0;
                end
            endcase
        end else begin
            case (d.va[63:62])
                HI_USER: begin
                    if (d.va > USER_TOP) begin
                        d.seg      = SEG_HOLE;
                        d.addr_err = 1'b1;
                    end else if (d.error_level_bit && d.va[63:31] == '0) begin
                        d.seg   = SEG_XUSER;
                        d.paddr = d.va[31:0];
                    end else begin
                        d.seg    = SEG_XUSER;
                        d.mapped = 1'b1;
                    end
                end
                HI_SUPER: begin
                    d.seg      = (d.va > SUPER_TOP) ? SEG_HOLE : SEG_XSUPER;
                    d.addr_err = d.va > SUPER_TOP;
                    d.mapped   = !(d.va > SUPER_TOP);
                end
                HI_PHYS: begin
                    d.seg       = SEG_XPHYS;
                    d.addr_err  = |d.va[58:32];
                    d.paddr     = d.va[31:0];
                    d.cacheable = kasd_cache_ok(d.va[61:59]);
                end
                default: begin
                    if (&d.va[63:31]) begin
                        case (d.va[30:29])
                            2'h0: begin
                                d.seg       = SEG_CCACHED;
                                d.paddr     = {3'h0, d.va[28:0]};
                                d.cacheable = kasd_cache_ok(d.direct_window_cache_field);
                            end
                            2'h1: begin
                                d.seg   = SEG_CUNCACHED;
                                d.paddr = {3'h0, d.va[28:0]};
                            end
                            2'h2: begin
                                d.seg    = SEG_CSUPER;
                                d.mapped = 1'b1;
                            end
                            default: begin
                                d.seg    = SEG_CKERNEL;
                                d.mapped = 1'b1;
                            end
                        endcase
                    end else if (d.va <= XKSEG_TOP) begin
                        d.seg    = SEG_XKERNEL;
                        d.mapped = 1'b1;
                    end else begin
                        d.seg      = SEG_HOLE;
                        d.addr_err = 1'b1;
                    end
                end
            endcase
        end
    end
endmodule

//--- rtl/kasd_top.sv
// Kernel address segment decoder with AHB-Lite control registers
//
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module kasd_top (
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic                             hreadyout,
    output logic                             hresp,
    output logic [31:0]                      hrdata,
    input  wire logic                        req_valid,
    input  wire logic [kasd_pkg::VA_W-1:0]   agen_base,
    input  wire logic [15:0]                 agen_offset,
    input  wire logic                        exc_take,
    input  wire logic                        exception_return_instruction,
    output logic                             kernel_level,
    output kasd_pkg::kasd_seg_type           seg,
    output logic                             mapped,
    output logic                             cacheable,
    output logic [kasd_pkg::PA_W-1:0]        paddr,
    output logic                             addr_err,
    output logic                             result_undefined,
    output logic [kasd_pkg::ID_W-1:0]        address_space_identifier
);
    import kasd_pkg::*;

    logic [1:0]       privilege_level_field_q;
    logic             exception_level_bit_q;
    logic             error_level_bit_q;
    logic             kernel_extended_addressing_bit_q;
    logic [2:0]       direct_window_cache_field_q;
    logic [ID_W-1:0]  space_id_q;
    logic             err_seen_q;
    logic [VA_W-1:0]  err_va_q;
    logic [CNT_W-1:0] err_cnt_q;
    logic             wr_pend_q;
    logic [11:0]      wr_addr_q;
    logic [31:0]      rdata_q;
    logic [31:0]      rd_val;
    logic             addr_phase;
    logic             wr_status;
    logic             wr_config;
    logic             wr_space;
    logic             wr_state;
    logic             err_event;
    logic [VA_W-1:0]  sum64;
    logic [VA_W-1:0]  va;

    kasd_dec_if dec_bus ();

    kasd_seg_decode u_decode (
        .d (dec_bus.dec)
    );

    // Address generation: base plus sign-extended 16-bit offset
    assign sum64 = agen_base + {{(VA_W-16){agen_offset[15]}}, agen_offset};

    // Narrow addressing decodes the sign-extended low word
    assign va = kernel_extended_addressing_bit_q ? sum64 :
                {{(VA_W-32){sum64[31]}}, sum64[31:0]};

    assign kernel_level = (privilege_level_field_q == PRIV_KERNEL)
                        || exception_level_bit_q
                        || error_level_bit_q;

    // Overflow out of bit 31 leaves the decode undefined; flagged only
    assign result_undefined = kernel_level && !kernel_extended_addressing_bit_q
        && ((!agen_offset[15] && !agen_base[31] && sum64[31])
        || (agen_offset[15] && agen_base[31] && !sum64[31]));

    assign dec_bus.kernel                    = kernel_level;
    assign dec_bus.ext64                     = kernel_extended_addressing_bit_q;
    assign dec_bus.error_level_bit           = error_level_bit_q;
    assign dec_bus.direct_window_cache_field = direct_window_cache_field_q;
    assign dec_bus.va                        = va;

    // Results are combinational so the pipeline sees them this cycle
    assign seg                      = dec_bus.seg;
    assign mapped                   = dec_bus.mapped;
    assign cacheable                = dec_bus.cacheable;
    assign paddr                    = dec_bus.paddr;
    assign addr_err                 = dec_bus.addr_err;
    assign address_space_identifier = space_id_q;

    // AHB-Lite slave, zero wait states, always OKAY
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = rdata_q;
    assign addr_phase = hsel && htrans[1] && hready;
    assign wr_status  = wr_pend_q && (wr_addr_q == OFS_STATUS);
    assign wr_config  = wr_pend_q && (wr_addr_q == OFS_CONFIG);
    assign wr_space   = wr_pend_q && (wr_addr_q == OFS_SPACE);
    assign wr_state   = wr_pend_q && (wr_addr_q == OFS_STATE);
    assign err_event  = req_valid && addr_err;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end else begin
            wr_pend_q <= addr_phase && hwrite;
            wr_addr_q <= haddr[11:0];
        end
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        case (haddr[11:0])
            OFS_STATUS: begin
                rd_val[ST_XADDR]       = kernel_extended_addressing_bit_q;
                rd_val[ST_EXC]         = exception_level_bit_q;
                rd_val[ST_ERRLVL]      = error_level_bit_q;
                rd_val[ST_PRIV +: 2]   = privilege_level_field_q;
            end
            OFS_CONFIG: rd_val[2:0]    = direct_window_cache_field_q;
            OFS_SPACE:  rd_val[ID_W-1:0] = space_id_q;
            OFS_STATE: begin
                rd_val[STA_KERNEL]     = kernel_level;
                rd_val[STA_EXT]        = kernel_extended_addressing_bit_q;
                rd_val[STA_ERR]        = err_seen_q;
            end
            OFS_ERR_LO: rd_val         = err_va_q[31:0];
            OFS_ERR_HI: rd_val         = err_va_q[63:32];
            OFS_ERR_CT: rd_val[CNT_W-1:0] = err_cnt_q;
            default:    rd_val         = 32'h0000_0000;
        endcase
    end

    // Read data is sampled in the address phase; an unmapped offset reads zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            rdata_q <= rd_val;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            privilege_level_field_q <= PRIV_RST;
        end else if (wr_status) begin
            privilege_level_field_q <= hwdata[ST_PRIV +: 2];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            kernel_extended_addressing_bit_q <= 1'b0;
        end else if (wr_status) begin
            kernel_extended_addressing_bit_q <= hwdata[ST_XADDR];
        end
    end

    // Privilege field is never touched by traps, so a return restores it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            exception_level_bit_q <= 1'b0;
        end else if (exc_take) begin
            exception_level_bit_q <= 1'b1;
        end else if (exception_return_instruction && !error_level_bit_q) begin
            exception_level_bit_q <= 1'b0;
        end else if (wr_status) begin
            exception_level_bit_q <= hwdata[ST_EXC];
        end
    end

    // A return clears the error level first when it is set
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            error_level_bit_q <= ERL_RST;
        end else if (exception_return_instruction && error_level_bit_q) begin
            error_level_bit_q <= 1'b0;
        end else if (wr_status) begin
            error_level_bit_q <= hwdata[ST_ERRLVL];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            direct_window_cache_field_q <= CFIELD_RST;
        end else if (wr_config) begin
            direct_window_cache_field_q <= hwdata[2:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            space_id_q <= SPACE_RST;
        end else if (wr_space) begin
            space_id_q <= hwdata[ID_W-1:0];
        end
    end

    // Sticky error flag: a new error beats a write-one clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            err_seen_q <= 1'b0;
        end else if (err_event) begin
            err_seen_q <= 1'b1;
        end else if (wr_state && hwdata[STA_ERR]) begin
            err_seen_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            err_va_q <= '0;
        end else if (err_event) begin
            err_va_q <= va;
        end
    end

    // Saturates rather than wraps so a flood stays visible
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            err_cnt_q <= '0;
        end else if (err_event && !(&err_cnt_q)) begin
            err_cnt_q <= err_cnt_q + CNT_W'(1);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_trap;
        exc_take && !error_level_bit_q && !wr_status;
    endsequence

    sequence s_return;
        exception_return_instruction && !exc_take && !wr_status;
    endsequence

    // Checked through the decoder so a wrong privilege term cannot hide
    a_kernel_decide: assert property (
        ((privilege_level_field_q == PRIV_KERNEL) || exception_level_bit_q
            || error_level_bit_q) == (seg != SEG_NONE))
        else $error("kernel level decision wrong");

    a_trap_enters_kernel: assert property (
        exc_take |=> kernel_level && exception_level_bit_q)
        else $error("exception did not enter kernel level");

    a_trap_return_mode: assert property (
        s_trap ##1 s_return |=> !exception_level_bit_q
            && privilege_level_field_q == $past(privilege_level_field_q, 2))
        else $error("return did not restore prior mode");

    a_narrow_sign_ext: assert property (
        !kernel_extended_addressing_bit_q |->
            va[63:32] == {32{sum64[31]}} && va[31:0] == sum64[31:0])
        else $error("narrow address not sign extended");

    a_overflow_flag: assert property (
        (kernel_level && !kernel_extended_addressing_bit_q
            && agen_offset[15] == agen_base[31]
            && sum64[31] != agen_base[31]) |-> result_undefined)
        else $error("overflow not flagged");

    a_user_mapped: assert property (
        (kernel_level && !kernel_extended_addressing_bit_q && !va[31]
            && !error_level_bit_q) |-> seg == SEG_USER && mapped)
        else $error("low user segment not mapped");

    a_error_level_low: assert property (
        (kernel_level && error_level_bit_q && va[63:31] == '0) |->
            !mapped && !cacheable && paddr == va[31:0])
        else $error("error level window not direct");

    a_cached_window: assert property (
        (kernel_level && !kernel_extended_addressing_bit_q
            && va[31:29] == TOP_CACHED) |-> !mapped
            && paddr == va[31:0] - CACHED_BASE
            && cacheable == (direct_window_cache_field_q != ATTR_UNCACHED))
        else $error("direct cached window wrong");

    a_uncached_window: assert property (
        (kernel_level && !kernel_extended_addressing_bit_q
            && va[31:29] == TOP_UNCACHED) |-> !mapped && !cacheable
            && paddr == va[31:0] - UNCACHED_BASE)
        else $error("direct uncached window wrong");

    a_phys_error: assert property (
        (kernel_level && kernel_extended_addressing_bit_q
            && va[63:62] == HI_PHYS) |->
            addr_err == (va[58:32] != '0) && paddr == va[31:0])
        else $error("physical window error check wrong");

    a_user_hole: assert property (
        (kernel_level && kernel_extended_addressing_bit_q
            && va[63:62] == HI_USER && va > USER_TOP) |->
            addr_err && seg == SEG_HOLE)
        else $error("user hole not flagged");

    a_compat_cached: assert property (
        (kernel_level && kernel_extended_addressing_bit_q && &va[63:31]
            && va[30:29] == 2'h0) |-> seg == SEG_CCACHED && !mapped
            && paddr == {3'h0, va[28:0]})
        else $error("compat cached window wrong");

    a_error_capture: assert property (
        err_event |=> err_seen_q && err_va_q == $past(va)
            && (err_cnt_q != $past(err_cnt_q) || &err_cnt_q))
        else $error("address error not recorded");
endmodule

//--- verif/kasd_pipe_model.sv
// Pipeline address generator model feeding the decoder
`timescale 1ns/1ns
module kasd_pipe_model (
    input  wire logic        ref_clk,
    output logic             req_valid,
    output logic [63:0]      agen_base,
    output logic [15:0]      agen_offset
);
    initial begin
        req_valid = 1'b0;
        agen_base = 64'h0000_0000_0000_0000;
        agen_offset = 16'h0000;
    end
    task automatic issue(input logic [63:0] b, input logic [15:0] o);
        @(posedge ref_clk);
        agen_base <= b;
        agen_offset <= o;
        req_valid <= 1'b1;
    endtask
    // Idle address is inverted so a stale decode cannot pass for a fresh one
    task automatic idle();
        @(posedge ref_clk);
        agen_base <= ~agen_base;
        agen_offset <= ~agen_offset;
        req_valid <= 1'b0;
    endtask
endmodule

//--- verif/kasd_top_bench.sv
// Self-checking bench for the kernel address segment decoder
`timescale 1ns/1ns
module kasd_top_bench;
    import kasd_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic exc_take = 1'b0, exc_ret = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic hreadyout, hresp, kernel_level, mapped, cacheable, addr_err, undef, req_valid;
    kasd_seg_type seg;
    logic [31:0] paddr;
    logic [7:0] space_id;
    logic [63:0] agen_base;
    logic [15:0] agen_offset;
    int n_fail = 0, compares = 0, cyc = 0;
    kasd_pipe_model pipe (.ref_clk(ref_clk), .req_valid(req_valid),
        .agen_base(agen_base), .agen_offset(agen_offset));
    kasd_top uut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .req_valid(req_valid),
        .agen_base(agen_base), .agen_offset(agen_offset), .exc_take(exc_take),
        .exception_return_instruction(exc_ret), .kernel_level(kernel_level), .seg(seg),
        .mapped(mapped), .cacheable(cacheable), .paddr(paddr), .addr_err(addr_err),
        .result_undefined(undef), .address_space_identifier(space_id));
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            results();
        end
    end
    task automatic results();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {20'h0_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 1'b0, hresp);
    endtask
    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask
    // Results are judged in the cycle the address is presented
    task automatic dec(input logic [63:0] b, input logic [15:0] o, input kasd_seg_type s,
        input logic m, input logic c, input logic [31:0] pa, input logic u);
        pipe.issue(b, o);
        #1;
        chk("seg", s, seg);
        chk("mapped", m, mapped);
        chk("cacheable", c, cacheable);
        chk("paddr", pa, paddr);
        chk("addr_err", 1'b0, addr_err);
        chk("undefined", u, undef);
        pipe.idle();
    endtask
    task automatic errx(input logic [63:0] b);
        pipe.issue(b, 16'h0000);
        #1;
        chk("addr_err", 1'b1, addr_err);
        pipe.idle();
    endtask
    task automatic t_reset();
        chk("kernel_level", 1'b1, kernel_level);
        rdchk("status", OFS_STATUS, 32'h0000_0004);
        rdchk("config", OFS_CONFIG, 32'h0000_0002);
        rdchk("unmapped", 12'h01C, 32'h0000_0000);
        dec(64'h0000_0000_0000_1000, 16'h0000, SEG_USER, 0, 0, 32'h0000_1000, 0);
    endtask
    task automatic t_seg32();
        ahb(1'b1, OFS_STATUS, 32'h0000_0000);
        ahb(1'b1, OFS_SPACE, 32'h0000_005A);
        dec(64'h0000_0000_0000_1000, 16'h0000, SEG_USER, 1, 0, 32'h0, 0);
        chk("space_id", 8'h5A, space_id);
        dec(64'h0000_0000_8000_1234, 16'h0000, SEG_DCACHED, 0, 0, 32'h0000_1234, 0);
        ahb(1'b1, OFS_CONFIG, 32'h0000_0003);
        dec(64'h0000_0000_9FFF_FFFC, 16'h0000, SEG_DCACHED, 0, 1, 32'h1FFF_FFFC, 0);
        dec(64'h0000_0000_A000_0020, 16'hFFF0, SEG_DUNCACHED, 0, 0, 32'h0000_0010, 0);
        dec(64'h0000_0000_7FFF_FFF0, 16'h0020, SEG_DCACHED, 0, 1, 32'h0000_0010, 1);
        dec(64'h0000_0000_C000_0000, 16'h0000, SEG_SUPER, 1, 0, 32'h0, 0);
        dec(64'hFFFF_FFFF_E000_0000, 16'h0000, SEG_KTOP, 1, 0, 32'h0, 0);
    endtask
    task automatic t_seg64();
        ahb(1'b1, OFS_STATUS, 32'h0000_0001);
        dec(64'h0000_00FF_FFFF_FFFF, 16'h0000, SEG_XUSER, 1, 0, 32'h0, 0);
        dec(64'h4000_0000_0000_1000, 16'h0000, SEG_XSUPER, 1, 0, 32'h0, 0);
        dec(64'h9000_0000_1234_5678, 16'h0000, SEG_XPHYS, 0, 0, 32'h1234_5678, 0);
        dec(64'hB800_0000_FFFF_FFFC, 16'h0000, SEG_XPHYS, 0, 1, 32'hFFFF_FFFC, 0);
        dec(64'hC000_00FF_7FFF_FFFF, 16'h0000, SEG_XKERNEL, 1, 0, 32'h0, 0);
        dec(64'hFFFF_FFFF_8000_0040, 16'h0000, SEG_CCACHED, 0, 1, 32'h40, 0);
        dec(64'hFFFF_FFFF_BFFF_FFFF, 16'h0000, SEG_CUNCACHED, 0, 0, 32'h1FFF_FFFF, 0);
        dec(64'hFFFF_FFFF_C000_0000, 16'h0000, SEG_CSUPER, 1, 0, 32'h0, 0);
        dec(64'hFFFF_FFFF_FFFF_FFFF, 16'h0000, SEG_CKERNEL, 1, 0, 32'h0, 0);
        ahb(1'b1, OFS_STATUS, 32'h0000_0005);
        dec(64'h0000_0000_7FFF_FFF0, 16'h0000, SEG_XUSER, 0, 0, 32'h7FFF_FFF0, 0);
    endtask
    task automatic t_errors();
        errx(64'h8400_0000_0000_0000);
        errx(64'h8000_0001_0000_0000);
        errx(64'h0000_0100_0000_0000);
        errx(64'h7FFF_FFFF_FFFF_FFFF);
        errx(64'hC000_00FF_8000_0000);
        errx(64'hFFFF_FFFF_7FFF_FFFF);
        rdchk("err_count", OFS_ERR_CT, 32'h0000_0006);
        rdchk("err_hi", OFS_ERR_HI, 32'hFFFF_FFFF);
        rdchk("err_lo", OFS_ERR_LO, 32'h7FFF_FFFF);
        rdchk("state", OFS_STATE, 32'h0000_0103);
        ahb(1'b1, OFS_STATE, 32'h0000_0100);
        rdchk("state", OFS_STATE, 32'h0000_0003);
    endtask
    task automatic t_except();
        ahb(1'b1, OFS_STATUS, 32'h0000_0018);
        dec(64'h0000_0000_8000_0000, 16'h0000, SEG_NONE, 0, 0, 32'h0, 0);
        exc_take <= 1'b1;
        @(posedge ref_clk);
        exc_take <= 1'b0;
        exc_ret <= 1'b1;
        #1 chk("kernel_level", 1'b1, kernel_level);
        @(posedge ref_clk);
        exc_ret <= 1'b0;
        #1 chk("kernel_level", 1'b0, kernel_level);
        rdchk("status", OFS_STATUS, 32'h0000_0018);
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_seg32();
        t_seg64();
        t_errors();
        t_except();
        results();
    end
endmodule
